// File: rtl/secg_defs.svh
// constants for the serial eeprom command guard
// assumes: included by secg_guard only
`ifndef SECG_DEFS_SVH
`define SECG_DEFS_SVH
`define SECG_WR_COMMIT_CLK   6'd27
`define SECG_ER_COMMIT_CLK   6'd11
`define SECG_OP_LAST_CLK     6'd3
`define SECG_ADDR_LAST_CLK   6'd11
`define SECG_RD_LAST_CLK     6'd27
`define SECG_MCLK_MHZ        100
`define SECG_PROG_TIME_MS    5
`define SECG_PROG_CYCLES     (`SECG_PROG_TIME_MS * 1000 * `SECG_MCLK_MHZ)
`define SECG_OP_EXT          2'h0
`define SECG_OP_WRITE        2'h1
`define SECG_OP_READ         2'h2
`define SECG_OP_ERASE        2'h3
`define SECG_EXT_DIS         2'h0
`define SECG_EXT_WRITE_ALL_WORDS        2'h1
`define SECG_EXT_ERASE_ALL_WORDS        2'h2
`define SECG_EXT_EN          2'h3
`endif

// File: rtl/secg_pkg.sv
// types for the serial eeprom command guard
// assumes: nothing beyond the defines header
package secg_pkg;
   typedef enum logic [2:0] {
      SECG_IDLE   = 3'b000,
      SECG_SHIFT  = 3'b001,
      SECG_READ   = 3'b010,
      SECG_ARMED  = 3'b011,
      SECG_SKIP   = 3'b100
   } secg_state_t;
endpackage : secg_pkg

// File: rtl/secg_sync.sv
// three-flop synchroniser with agreement filter for one level
// assumes: d_i is asynchronous to clk_i
module secg_sync (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_q;

   // shift in; output changes only once stages two and three agree
   always_comb begin
      next_stage = {stage[1:0], d_i};
      next_q     = (stage[2] == stage[1]) ? stage[2] : q_o;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage <= 3'h0;
         q_o   <= 1'b0;
      end else begin
         stage <= next_stage;
         q_o   <= next_q;
      end
   end
endmodule : secg_sync

// File: rtl/secg_guard.sv
// serial eeprom command guard: decode, cancel window, program timer
// assumes: serial_clock is the link clock; chip select and data-in are
// sampled on it; the program timer runs on mclk_i
`include "secg_defs.svh"
module secg_guard #(
   parameter int unsigned PROG_CYCLES = `SECG_PROG_CYCLES
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        serial_clock_i,
   input  wire logic        chip_sel_i,
   input  wire logic        serial_in_i,
   input  wire logic        low_supply_lockout_i,
   input  wire logic [15:0] read_data_i,
   output logic             data_out_o,
   output logic             data_out_oe_o,
   output logic             prog_start_o,
   output logic             prog_is_erase_o,
   output logic             prog_all_o,
   output logic [6:0]       prog_addr_o,
   output logic [15:0]      prog_data_o,
   output logic             busy_o,
   output logic             write_enabled_o
);
   // -------------------------------------------------------------
   // link side (serial_clock domain)
   // -------------------------------------------------------------
   secg_pkg::secg_state_t state;
   secg_pkg::secg_state_t next_state;
   logic [5:0]  clk_cnt;
   logic [5:0]  next_clk_cnt;
   logic [9:0]  cmd;
   logic [9:0]  next_cmd;
   logic [15:0] wdata;
   logic [15:0] next_wdata;
   logic [15:0] rshift;
   logic [15:0] next_rshift;
   logic [6:0]  rd_addr;
   logic [6:0]  next_rd_addr;
   logic        wen;
   logic        next_wen;
   logic        req_tgl;
   logic        next_req_tgl;
   logic        req_erase;
   logic        next_req_erase;
   logic        req_all;
   logic        next_req_all;
   logic        rd_drive;
   logic        next_rd_drive;
   logic        busy_l1;
   logic        busy_l2;
   logic        busy_link;
   logic        ready_shown;
   logic        next_ready_shown;
   logic        prog_pending;
   logic        next_prog_pending;

   // busy from the mclk domain into the link domain, two flops
   always_ff @(posedge serial_clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_l1 <= 1'b0;
         busy_l2 <= 1'b0;
      end else begin
         busy_l1 <= busy_o;
         busy_l2 <= busy_l1;
      end
   end
   assign busy_link = busy_l2;

   // instruction decode; chip select low returns to idle and clears the clock count
   always_comb begin
      next_state        = state;
      next_clk_cnt      = clk_cnt;
      next_cmd          = cmd;
      next_wdata        = wdata;
      next_rshift       = rshift;
      next_rd_addr      = rd_addr;
      next_wen          = wen;
      next_req_tgl      = req_tgl;
      next_req_erase    = req_erase;
      next_req_all      = req_all;
      next_rd_drive     = 1'b0;
      next_ready_shown  = ready_shown;
      next_prog_pending = prog_pending;
      if (!chip_sel_i) begin
         // abort and commit are decided at the chip select drop
         if (state == secg_pkg::SECG_ARMED) begin
            next_req_tgl      = ~req_tgl;
            next_prog_pending = 1'b1;
         end
         next_state   = secg_pkg::SECG_IDLE;
         next_clk_cnt = 6'h0;
      end else if (busy_link || prog_pending) begin
         // ignore input while programming; pending clears once seen busy
         if (busy_link) next_prog_pending = 1'b0;
         next_ready_shown = 1'b1;
      end else begin
         case (state)
            secg_pkg::SECG_IDLE: begin
               if (serial_in_i) begin
                  next_state       = secg_pkg::SECG_SHIFT;
                  next_clk_cnt     = 6'h1;
                  next_ready_shown = 1'b0;
               end
            end
            secg_pkg::SECG_SHIFT: begin
               next_clk_cnt = clk_cnt + 6'h1;
               // opcode and address only; data bits must not push them out
               if (clk_cnt < `SECG_ADDR_LAST_CLK)
                  next_cmd  = {cmd[8:0], serial_in_i};
               if (clk_cnt == `SECG_ADDR_LAST_CLK - 6'h1) begin
                  case (next_cmd[9:8])
                     `SECG_OP_READ: begin
                        next_state    = secg_pkg::SECG_READ;
                        next_rd_addr  = next_cmd[6:0];
                        next_rd_drive = 1'b1;
                        next_rshift   = 16'h0;               // dummy zero
                     end
                     `SECG_OP_ERASE: begin
                        next_state     = (wen && !low_supply_lockout_i)
                                         ? secg_pkg::SECG_ARMED
                                         : secg_pkg::SECG_SKIP;
                        next_req_erase = 1'b1;
                        next_req_all   = 1'b0;
                     end
                     `SECG_OP_WRITE: begin
                        next_req_erase = 1'b0;
                        next_req_all   = 1'b0;
                     end
                     default: begin
                        case (next_cmd[7:6])
                           `SECG_EXT_EN:  begin
                              next_wen   = 1'b1;
                              next_state = secg_pkg::SECG_SKIP;
                           end
                           `SECG_EXT_DIS: begin
                              next_wen   = 1'b0;
                              next_state = secg_pkg::SECG_SKIP;
                           end
                           `SECG_EXT_ERASE_ALL_WORDS: begin
                              next_state     = (wen && !low_supply_lockout_i)
                                               ? secg_pkg::SECG_ARMED
                                               : secg_pkg::SECG_SKIP;
                              next_req_erase = 1'b1;
                              next_req_all   = 1'b1;
                           end
                           default: begin
                              next_req_erase = 1'b0;
                              next_req_all   = 1'b1;
                           end
                        endcase
                     end
                  endcase
               end else if (clk_cnt >= `SECG_ADDR_LAST_CLK) begin
                  next_wdata = {wdata[14:0], serial_in_i};
                  if (clk_cnt == `SECG_WR_COMMIT_CLK - 6'h1)
                     next_state = (wen && !low_supply_lockout_i)
                                  ? secg_pkg::SECG_ARMED
                                  : secg_pkg::SECG_SKIP;
               end
            end
            secg_pkg::SECG_READ: begin
               // sequential read keeps streaming words
               next_rd_drive = 1'b1;
               next_clk_cnt  = clk_cnt + 6'h1;
               if (clk_cnt == `SECG_ADDR_LAST_CLK ||
                   clk_cnt == `SECG_RD_LAST_CLK) begin
                  next_rshift  = read_data_i;
                  next_clk_cnt = `SECG_ADDR_LAST_CLK + 6'h1;
                  if (clk_cnt == `SECG_RD_LAST_CLK)
                     next_rd_addr = rd_addr + 7'h1;
               end else begin
                  next_rshift = {rshift[14:0], 1'b0};
               end
            end
            secg_pkg::SECG_ARMED: begin
               next_state = secg_pkg::SECG_ARMED;
            end
            secg_pkg::SECG_SKIP: begin
               next_state = secg_pkg::SECG_SKIP;
            end
            default: next_state = secg_pkg::SECG_IDLE;
         endcase
      end
   end

   always_ff @(posedge serial_clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state        <= secg_pkg::SECG_IDLE;
         clk_cnt      <= 6'h0;
         cmd          <= 10'h0;
         wdata        <= 16'h0;
         rshift       <= 16'h0;
         rd_addr      <= 7'h0;
         wen          <= 1'b0;
         req_tgl      <= 1'b0;
         req_erase    <= 1'b0;
         req_all      <= 1'b0;
         rd_drive     <= 1'b0;
         ready_shown  <= 1'b0;
         prog_pending <= 1'b0;
      end else begin
         state        <= next_state;
         clk_cnt      <= next_clk_cnt;
         cmd          <= next_cmd;
         wdata        <= next_wdata;
         rshift       <= next_rshift;
         rd_addr      <= next_rd_addr;
         wen          <= next_wen;
         req_tgl      <= next_req_tgl;
         req_erase    <= next_req_erase;
         req_all      <= next_req_all;
         rd_drive     <= next_rd_drive;
         ready_shown  <= next_ready_shown;
         prog_pending <= next_prog_pending;
      end
   end

   // -------------------------------------------------------------
   // core side (mclk domain)
   // -------------------------------------------------------------
   logic        cs_sync;
   logic        tgl_sync;
   logic        rd_sync;
   logic        rdy_sync;
   logic        wen_sync;
   logic        tgl_seen;
   logic        next_tgl_seen;
   logic [31:0] timer;
   logic [31:0] next_timer;
   logic        next_busy;
   logic        next_start;
   logic        next_dout;
   logic        next_oe;
   logic [6:0]  addr_hold;
   logic [6:0]  next_addr_hold;

   // link-domain levels enter through agreement filters
   secg_sync u_cs  (.clk_i(mclk_i), .rst_n_i(rst_n_i),
                    .d_i(chip_sel_i),  .q_o(cs_sync));
   secg_sync u_tgl (.clk_i(mclk_i), .rst_n_i(rst_n_i),
                    .d_i(req_tgl),     .q_o(tgl_sync));
   secg_sync u_rd  (.clk_i(mclk_i), .rst_n_i(rst_n_i),
                    .d_i(rd_drive),    .q_o(rd_sync));
   secg_sync u_rdy (.clk_i(mclk_i), .rst_n_i(rst_n_i),
                    .d_i(ready_shown), .q_o(rdy_sync));
   secg_sync u_wen (.clk_i(mclk_i), .rst_n_i(rst_n_i),
                    .d_i(wen),         .q_o(wen_sync));

   // a toggle starts the self-timed cycle; nothing can stop it
   // command fields are stable while the toggle crosses
   always_comb begin
      next_tgl_seen  = tgl_sync;
      next_timer     = timer;
      next_busy      = busy_o;
      next_start     = 1'b0;
      next_addr_hold = addr_hold;
      if (tgl_sync != tgl_seen) begin
         next_busy      = 1'b1;
         next_start     = 1'b1;
         next_timer     = PROG_CYCLES - 32'd1;
         next_addr_hold = cmd[6:0];
      end else if (busy_o) begin
         if (timer == 32'd0) next_busy = 1'b0;
         else next_timer = timer - 32'd1;
      end
      // read data while reading, else busy low, ready high, else released
      next_oe   = cs_sync && (rd_sync || busy_o || rdy_sync);
      next_dout = rd_sync ? rshift[15] : !busy_o;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tgl_seen        <= 1'b0;
         timer           <= 32'h0;
         busy_o          <= 1'b0;
         prog_start_o    <= 1'b0;
         prog_is_erase_o <= 1'b0;
         prog_all_o      <= 1'b0;
         prog_addr_o     <= 7'h0;
         prog_data_o     <= 16'h0;
         addr_hold       <= 7'h0;
         data_out_o      <= 1'b0;
         data_out_oe_o   <= 1'b0;
         write_enabled_o <= 1'b0;
      end else begin
         tgl_seen        <= next_tgl_seen;
         timer           <= next_timer;
         busy_o          <= next_busy;
         prog_start_o    <= next_start;
         prog_is_erase_o <= next_start ? req_erase : prog_is_erase_o;
         prog_all_o      <= next_start ? req_all : prog_all_o;
         prog_addr_o     <= next_start ? cmd[6:0] : prog_addr_o;
         prog_data_o     <= next_start ? wdata : prog_data_o;
         addr_hold       <= next_addr_hold;
         data_out_o      <= next_dout;
         data_out_oe_o   <= next_oe;
         write_enabled_o <= wen_sync;
      end
   end
endmodule : secg_guard

// File: test/secg_checker.sv
// checker: port timing of the command guard in the mclk domain
// assumes: bound into every secg_guard, sees its ports only
module secg_checker #(
   parameter int unsigned PROG_CYCLES = 50
) (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic        low_supply_lockout_i,
   input wire logic        data_out_o,
   input wire logic        data_out_oe_o,
   input wire logic        prog_start_o,
   input wire logic [6:0]  prog_addr_o,
   input wire logic [15:0] prog_data_o,
   input wire logic        busy_o,
   input wire logic        write_enabled_o
);
   default clocking dc @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   int unsigned busy_cnt;
   int unsigned next_busy_cnt;
   // busy run length: a counter, the run is too long to unroll
   always_comb begin
      next_busy_cnt = busy_o ? busy_cnt + 1 : 0;
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= next_busy_cnt;
      end
   end
   // a commit is a one-cycle pulse, then a steady busy run
   sequence s_start;
      prog_start_o;
   endsequence
   sequence s_busy_run;
      busy_o [*4];
   endsequence
   a_start_busy:
      assert property (s_start |-> ##[0:2] s_busy_run)
      else $error("busy missing after start");
   a_start_pulse:
      assert property (s_start |=> !prog_start_o)
      else $error("start pulse too long");
   a_busy_time:
      assert property ($fell(busy_o) |-> busy_cnt == PROG_CYCLES)
      else $error("program cycle length wrong");
   a_no_restart:
      assert property (s_start |-> !$past(busy_o))
      else $error("start during busy");
   a_needs_enable:
      assert property (s_start |-> write_enabled_o)
      else $error("start while write disabled");
   a_lockout_blocks:
      assert property (s_start |-> !low_supply_lockout_i)
      else $error("start under supply lockout");
   a_busy_shows_low:
      assert property (busy_o && $past(busy_o) && data_out_oe_o |-> !data_out_o)
      else $error("status high while busy");
   a_fields_hold:
      assert property (busy_o && $past(busy_o) |->
         $stable(prog_addr_o) && $stable(prog_data_o))
      else $error("command fields moved while busy");
   a_reset_disabled:
      assert property ($rose(rst_n_i) |-> !write_enabled_o)
      else $error("write enabled after reset");
endmodule : secg_checker

bind secg_guard secg_checker #(.PROG_CYCLES(PROG_CYCLES)) u_checker (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .busy_o(busy_o),
   .low_supply_lockout_i(low_supply_lockout_i), .data_out_o(data_out_o),
   .data_out_oe_o(data_out_oe_o), .prog_start_o(prog_start_o),
   .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o),
   .write_enabled_o(write_enabled_o)
);

// File: test/secg_host.sv
// host model: drives select, serial clock and data-in of the guard
// assumes: the bench calls one task at a time
module secg_host (
   output logic serial_clock_o,
   output logic chip_sel_o,
   output logic serial_in_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // parked: clock still, select low through power ramps
   initial begin
      serial_clock_o = 1'b0;
      chip_sel_o     = 1'b0;
      serial_in_o    = 1'b1;
   end
   // one link clock period of 30 ns, runs only on demand
   task automatic pulse();
      #15 serial_clock_o = 1'b1;
      #15 serial_clock_o = 1'b0;
   endtask : pulse
   // first n bits of b, msb first; the trailing clock with select low
   // is what lets the guard see the drop
   task automatic frame(input logic [31:0] b, input int n);
      serial_in_o = 1'b0;
      chip_sel_o  = 1'b1;
      for (int i = 0; i < n; i++) begin
         serial_in_o = b[31-i];
         pulse();
      end
      chip_sel_o  = 1'b0;
      serial_in_o = ~serial_in_o;
      pulse();
   endtask : frame
   // clocks with select low and data-in high
   task automatic stray(input int n);
      serial_in_o = 1'b1;
      repeat (n) pulse();
   endtask : stray
endmodule : secg_host

// File: test/testbench.sv
// testbench: guard against the host model and a queue of commits
// assumes: program timer shortened to PROG mclk cycles
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned PROG = 50;
   logic        mclk, rst_n, lock, data_out, data_oe, start, is_erase;
   logic        all_w, sclk, cs, din, busy, wen, we;
   logic [15:0] rdata, pdata;
   logic [6:0]  addr;
   logic [31:0] got;
   logic [31:0] exp_q[$], msk_q[$];
   int          errors, checked;
   always #5 mclk = ~mclk;
   secg_guard #(.PROG_CYCLES(PROG)) dut (
      .mclk_i(mclk), .rst_n_i(rst_n), .serial_clock_i(sclk),
      .chip_sel_i(cs), .serial_in_i(din), .low_supply_lockout_i(lock),
      .read_data_i(rdata), .data_out_o(data_out), .data_out_oe_o(data_oe),
      .prog_start_o(start), .prog_is_erase_o(is_erase), .prog_all_o(all_w),
      .prog_addr_o(addr), .prog_data_o(pdata), .busy_o(busy),
      .write_enabled_o(wen)
   );
   secg_host host (.serial_clock_o(sclk), .chip_sel_o(cs), .serial_in_o(din));
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   // every start must match the oldest expected command
   always @(posedge mclk) begin
      if (start === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unexpected start", 32'h0, 32'h1);
         end else begin
            got = {7'h0, is_erase, all_w, addr, pdata} & msk_q[0];
            chk("command", exp_q[0], got);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
         end
      end
   end
   // kinds: 0 write, 1 write all, 2 erase, 3 erase all, 4 enable,
   // 5 disable, 6 read; n counts clocks from the start bit
   task automatic run(input int k, input int n, input int lead,
                      input logic lk);
      logic [1:0]  opt[7] = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h2};
      logic [1:0]  ext[7] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0, 2'h0};
      logic [7:0]  a;
      logic [15:0] d;
      logic [31:0] m;
      int          w;
      a = 8'($urandom());
      d = 16'($urandom());
      if (opt[k] == 2'h0) begin
         a[7:6] = ext[k];
      end
      m = {7'h0, 2'h3, (k == 0 || k == 2) ? 7'h7f : 7'h0,
           (k < 2) ? 16'hffff : 16'h0};
      @(posedge mclk);
      #1;
      lock  = lk;
      rdata = 16'($urandom());
      // a commit needs the full count, enable and a healthy supply
      if (k < 4 && n >= ((k < 2) ? 27 : 11) && we && !lk) begin
         exp_q.push_back(m & {7'h0, k > 1, k % 2 == 1, a[6:0], d});
         msk_q.push_back(m);
      end
      // two extra leading zeros: the guard sees busy end two clocks late
      host.frame({1'b1, opt[k], a, d, 5'h0} >> (lead + 2), n + lead + 2);
      if ((k == 4 || k == 5) && n >= 11) begin
         we = (k == 4);
      end
      repeat (20) @(posedge mclk);
      if (busy === 1'b1) begin
         host.frame(32'hffffffff, 6);
      end
      w = 0;
      while (busy !== 1'b0 && w < 300) begin
         @(posedge mclk);
         w++;
      end
      if (w == 300) begin
         chk("busy timeout", 32'h0, 32'h1);
         conclude();
      end
      #1;
      lock = 1'b0;
      chk("pending starts", 32'h0, 32'(exp_q.size()));
      chk("write enable", {31'h0, we}, {31'h0, wen});
      chk("data out enable", 32'h0, {31'h0, data_oe});
      $display("test kind %0d clocks %0d done", k, n);
   endtask : run
   // reset, then refusals, cancel windows and commits for each mode
   initial begin
      mclk    = 1'b0;
      rst_n   = 1'b0;
      lock    = 1'b0;
      rdata   = 16'h0;
      we      = 1'b0;
      errors  = 0;
      checked = 0;
      void'($urandom(32'hfd69));
      repeat (20) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      repeat (5) @(posedge mclk);
      run(0, 27, 0, 1'b0);
      run(4, 11, 3, 1'b0);
      for (int k = 0; k < 4; k++) begin
         run(k, (k < 2) ? 26 : 10, 0, 1'b0);
         run(k, (k < 2) ? 27 : 11, 0, 1'b0);
      end
      run(6, 15, 0, 1'b0);
      run(0, 27, 0, 1'b1);
      host.stray(8);
      run(5, 11, 0, 1'b0);
      run(2, 11, 0, 1'b0);
      conclude();
   end
endmodule : testbench
